// File: src/dspr_params.svh
// constants for the debug system power and reset request block
`ifndef DSPR_PARAMS_SVH
`define DSPR_PARAMS_SVH

// ****************************************************************
// device register offsets (12-bit byte addresses)
// ****************************************************************
`define DSPR_OFS_PCR        12'hB00
`define DSPR_OFS_PSR        12'hB80
`define DSPR_OFS_RSTRR      12'hC18
`define DSPR_OFS_RSTAR      12'hC1C
`define DSPR_BANK_MASK      12'hF80

// ****************************************************************
// device field positions and codes
// ****************************************************************
`define DSPR_BIT_PRESENT    0
`define DSPR_BIT_PR         1
`define DSPR_BIT_RR         0
`define DSPR_BIT_RA         0
`define DSPR_PS_OFF         2'h0
`define DSPR_PS_ON          2'h1
`define DSPR_PS_HELD        2'h3
`define DSPR_RST_PR         32'h0000_0000
`define DSPR_RST_RR         1'h0
`define DSPR_RST_RA         1'h0

// ****************************************************************
// controller register offsets and fields
// ****************************************************************
`define DSPR_HOFS_CMD       8'h00
`define DSPR_HOFS_STAT      8'h04
`define DSPR_CMD_DOM_LSB    0
`define DSPR_CMD_OP_LSB     8
`define DSPR_CMD_VAL_BIT    12
`define DSPR_STAT_BUSY      0
`define DSPR_STAT_REFUSED   1
`define DSPR_STAT_PS_LSB    2
`define DSPR_STAT_RA        4

`endif

// File: src/dspr_pkg.sv
// types shared by both ends of the debug power and reset request link
package dspr_pkg;

    // controller operations, code = value of the op field
    typedef enum logic [1:0] {
        DSPR_OP_POLL,
        DSPR_OP_ON,
        DSPR_OP_OFF,
        DSPR_OP_RST
    } dspr_op_t;

    // controller sequencer states
    typedef enum logic [2:0] {
        DSPR_H_IDLE,
        DSPR_H_CHK,
        DSPR_H_CHK_W,
        DSPR_H_WRITE,
        DSPR_H_WR_W,
        DSPR_H_ACK,
        DSPR_H_ACK_W
    } dspr_hstate_t;

    // whole state of the device end
    typedef struct packed {
        logic [31:0] pr;        // power request bits
        logic [31:0] held;      // domains shown as powered and held
        logic [31:0] pwr_req;   // demand to the power controller
        logic        rr;        // reset request bit
        logic        ra;        // reset acknowledge bit
        logic        rst_req;   // request to the reset controller
        logic        rsp_valid; // answer strobe on the link
        logic [31:0] rdata;     // answer data on the link
    } dspr_dev_state_t;

    // whole state of the controller end
    typedef struct packed {
        dspr_hstate_t st;       // sequencer state
        dspr_op_t     op;       // operation in progress
        logic [4:0]   dom;      // target domain
        logic         val;      // reset request value to write
        logic         refused;  // last power-on refused
        logic [1:0]   last_ps;  // last status field read
        logic         ra;       // last reset acknowledge read
        logic         req_valid;
        logic         req_write;
        logic [11:0]  req_addr;
        logic [31:0]  req_wdata;
        logic         pready;
        logic [31:0]  prdata;
        logic         pslverr;
    } dspr_host_state_t;

endpackage

// File: src/dspr_link_if.sv
// register link between the debug controller and the request block
`timescale 1ns/1ps
`default_nettype none

interface dspr_link_if;
    logic        req_valid;   // one-cycle request strobe
    logic        req_write;   // 1 write, 0 read
    logic [11:0] req_addr;    // byte address
    logic [31:0] req_wdata;   // write data
    logic        rsp_valid;   // one-cycle answer strobe
    logic [31:0] rsp_rdata;   // read data, zero for writes

    // device end
    modport dev (
        input  req_valid,
        input  req_write,
        input  req_addr,
        input  req_wdata,
        output rsp_valid,
        output rsp_rdata
    );

    // controller end
    modport ctl (
        output req_valid,
        output req_write,
        output req_addr,
        output req_wdata,
        input  rsp_valid,
        input  rsp_rdata
    );
endinterface

`default_nettype wire

// File: src/dspr_dev.sv
// device end: power request and system reset request registers

`timescale 1ns/1ps
`default_nettype none

`include "dspr_params.svh"

module dspr_dev #(
    parameter logic [31:0] IMPL_MASK = 32'hFFFF_FFFF, // implemented domains
    parameter bit          HOLD_MODE = 1'b1,          // 1 reports 11, 0 reports 01
    parameter bit          RST_IMPL  = 1'b1,          // reset registers present
    parameter bit          IGNORE_WR = 1'b1           // drop writes while ignored
) (
    input  wire logic        i_clk_sys,     // register clock
    input  wire logic        i_arst_n,      // power-on reset, active low
    dspr_link_if.dev         link,          // register link
    input  wire logic [31:0] i_pwr_ack,     // power controller: domain powered
    input  wire logic        i_rst_ack,     // reset controller: reset initiated
    input  wire logic        i_rst_ignore,  // system resets currently ignored
    output logic      [31:0] o_pwr_req,     // power demand per domain
    output logic             o_rst_req      // system reset request
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // address falls in a 32-word bank
    // mask drops the word index
    function automatic logic in_bank(input logic [11:0] addr,
                                     input logic [11:0] base);
        in_bank = (addr & `DSPR_BANK_MASK) == base;
    endfunction

    // status field of one domain from the current state
    // plain mode shows the live ack
    function automatic logic [1:0] ps_of(input dspr_pkg::dspr_dev_state_t s,
                                         input logic [31:0] ack,
                                         input logic [4:0] n);
        if (!IMPL_MASK[n]) begin
            ps_of = `DSPR_PS_OFF;            // absent domain reads zero
        end else if (HOLD_MODE) begin
            // held only after power seen
            ps_of = s.held[n] ? `DSPR_PS_HELD : `DSPR_PS_OFF;
        end else begin
            // plain powered indication
            ps_of = ack[n] ? `DSPR_PS_ON : `DSPR_PS_OFF;
        end
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************

    // whole state, one packed struct
    dspr_pkg::dspr_dev_state_t cur;       // registered state
    dspr_pkg::dspr_dev_state_t next_cur;  // next state

    // one-cycle access decode
    logic [4:0] idx;   // domain index of the current access
    logic       wr;    // write request this cycle
    logic       rd;    // read request this cycle

    assign idx = link.req_addr[6:2];
    assign wr  = link.req_valid & link.req_write;
    assign rd  = link.req_valid & ~link.req_write;

    // ****************************************************************
    // next-state logic
    // ****************************************************************

    // hold every field unless changed
    always_comb begin
        next_cur           = cur;
        next_cur.rsp_valid = link.req_valid;   // every request answered next cycle
        next_cur.rdata     = 32'h0000_0000;

        // register writes
        if (wr) begin
            // one word per domain
            if (in_bank(link.req_addr, `DSPR_OFS_PCR)) begin
                // only implemented domains take the bit
                if (IMPL_MASK[idx]) begin
                    next_cur.pr[idx] = link.req_wdata[`DSPR_BIT_PR];
                end
            end else if (link.req_addr == `DSPR_OFS_RSTRR) begin
                // absent or ignored reset requests drop the write
                if (RST_IMPL && !(IGNORE_WR && i_rst_ignore)) begin
                    next_cur.rr = link.req_wdata[`DSPR_BIT_RR];
                end
            end
        end

        // four-phase power handshake per domain
        // a lost ack does not end it,
        // only a cleared request does
        for (int i = 0; i < 32; i++) begin
            if (HOLD_MODE && IMPL_MASK[i]) begin
                // enter on acknowledge, leave when request drops
                next_cur.held[i] = next_cur.pr[i] & (cur.held[i] | i_pwr_ack[i]);
            end else begin
                // plain mode or absent
                next_cur.held[i] = 1'b0;
            end
        end

        // demand follows the request bit and so covers the held span
        // absent domains never demand
        next_cur.pwr_req = next_cur.pr & IMPL_MASK;

        // reset request out, suppressed while the system ignores it
        // bit kept while ignored
        next_cur.rst_req = RST_IMPL & next_cur.rr & ~i_rst_ignore;

        // reset acknowledge: set on initiation, clear on completion
        // clear needs both sides low
        if (cur.rst_req && i_rst_ack) begin
            next_cur.ra = 1'b1;                 // set wins over clear
        end else if (!cur.rr && !i_rst_ack) begin
            next_cur.ra = 1'b0;
        end

        // absent reset logic
        if (!RST_IMPL) begin
            next_cur.ra = 1'b0;
        end

        // register reads
        // unmapped words read zero
        if (rd) begin
            if (in_bank(link.req_addr, `DSPR_OFS_PCR)) begin
                // present flag and request bit
                next_cur.rdata[`DSPR_BIT_PRESENT] = IMPL_MASK[idx];
                // request bit as written
                next_cur.rdata[`DSPR_BIT_PR]      = cur.pr[idx] & IMPL_MASK[idx];
            end else if (in_bank(link.req_addr, `DSPR_OFS_PSR)) begin
                // held flag or live ack
                next_cur.rdata[1:0] = ps_of(cur, i_pwr_ack, idx);
            end else if (link.req_addr == `DSPR_OFS_RSTRR) begin
                // zero when absent
                next_cur.rdata[`DSPR_BIT_RR] = RST_IMPL & cur.rr;
            end else if (link.req_addr == `DSPR_OFS_RSTAR) begin
                // last registered ack
                next_cur.rdata[`DSPR_BIT_RA] = RST_IMPL & cur.ra;
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************

    // async clear, else next state
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            // power-on reset clears every bit
            cur.pr        <= `DSPR_RST_PR;
            cur.held      <= 32'h0000_0000;
            cur.pwr_req   <= 32'h0000_0000;
            cur.rr        <= `DSPR_RST_RR;
            cur.ra        <= `DSPR_RST_RA;
            cur.rst_req   <= 1'h0;
            // no answer pending
            cur.rsp_valid <= 1'h0;
            cur.rdata     <= 32'h0000_0000;
        end else begin
            // one flop stage for all
            cur <= next_cur;
        end
    end

    // ****************************************************************
    // outputs, all straight from the state register
    // ****************************************************************

    // flops straight to pins
    assign o_pwr_req      = cur.pwr_req;
    assign o_rst_req      = cur.rst_req;
    assign link.rsp_valid = cur.rsp_valid;
    assign link.rsp_rdata = cur.rdata;

endmodule

`default_nettype wire

// File: src/dspr_ctl.sv
// controller end: APB command registers driving the request link
`timescale 1ns/1ps
`default_nettype none

`include "dspr_params.svh"

module dspr_ctl (
    input  wire logic        i_clk_sys,   // register clock
    input  wire logic        i_arst_n,    // asynchronous reset, active low
    input  wire logic        i_psel,      // APB select
    input  wire logic        i_penable,   // APB enable
    input  wire logic        i_pwrite,    // APB direction
    input  wire logic [7:0]  i_paddr,     // APB byte address
    input  wire logic [31:0] i_pwdata,    // APB write data
    output logic             o_pready,    // APB ready
    output logic      [31:0] o_prdata,    // APB read data
    output logic             o_pslverr,   // APB error, unmapped address
    dspr_link_if.ctl         link         // register link
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // address of a domain's word in a per-domain bank
    function automatic logic [11:0] dom_addr(input logic [11:0] base,
                                             input logic [4:0] dom);
        dom_addr = base | {5'h00, dom, 2'h0};
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    dspr_pkg::dspr_host_state_t cur;       // registered state
    dspr_pkg::dspr_host_state_t next_cur;  // next state

    logic setup;    // APB setup cycle
    logic access;   // APB access completing this edge
    logic mapped;   // address hits a register

    assign setup  = i_psel & ~i_penable & ~cur.pready;
    assign access = i_psel & i_penable & cur.pready;
    assign mapped = (i_paddr == `DSPR_HOFS_CMD) | (i_paddr == `DSPR_HOFS_STAT);

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        next_cur           = cur;
        next_cur.req_valid = 1'b0;
        next_cur.pready    = 1'b0;
        next_cur.pslverr   = 1'b0;
        next_cur.prdata    = 32'h0000_0000;

        // APB setup: answer ready for the access phase
        if (setup) begin
            next_cur.pready  = 1'b1;
            next_cur.pslverr = ~mapped;
            if (i_paddr == `DSPR_HOFS_STAT && !i_pwrite) begin
                next_cur.prdata[`DSPR_STAT_BUSY]    = cur.st != dspr_pkg::DSPR_H_IDLE;
                next_cur.prdata[`DSPR_STAT_REFUSED] = cur.refused;
                next_cur.prdata[`DSPR_STAT_PS_LSB +: 2] = cur.last_ps;
                next_cur.prdata[`DSPR_STAT_RA]      = cur.ra;
            end
        end

        // sequencer
        case (cur.st)
            dspr_pkg::DSPR_H_IDLE: begin
                // command taken only while idle
                if (access && i_pwrite && i_paddr == `DSPR_HOFS_CMD) begin
                    next_cur.dom     = i_pwdata[`DSPR_CMD_DOM_LSB +: 5];
                    next_cur.op      = dspr_pkg::dspr_op_t'(i_pwdata[`DSPR_CMD_OP_LSB +: 2]);
                    next_cur.val     = i_pwdata[`DSPR_CMD_VAL_BIT];
                    next_cur.refused = 1'b0;
                    if (next_cur.op == dspr_pkg::DSPR_OP_POLL ||
                        next_cur.op == dspr_pkg::DSPR_OP_ON) begin
                        next_cur.st = dspr_pkg::DSPR_H_CHK;
                    end else begin
                        next_cur.st = dspr_pkg::DSPR_H_WRITE;
                    end
                end
            end
            dspr_pkg::DSPR_H_CHK: begin
                // read the domain's status
                next_cur.req_valid = 1'b1;
                next_cur.req_write = 1'b0;
                next_cur.req_addr  = dom_addr(`DSPR_OFS_PSR, cur.dom);
                next_cur.st        = dspr_pkg::DSPR_H_CHK_W;
            end
            dspr_pkg::DSPR_H_CHK_W: begin
                if (link.rsp_valid) begin
                    next_cur.last_ps = link.rsp_rdata[1:0];
                    if (cur.op != dspr_pkg::DSPR_OP_ON) begin
                        next_cur.st = dspr_pkg::DSPR_H_ACK;
                    end else if (link.rsp_rdata[1:0] == `DSPR_PS_HELD) begin
                        // earlier handshake not yet closed
                        next_cur.refused = 1'b1;
                        next_cur.st      = dspr_pkg::DSPR_H_IDLE;
                    end else begin
                        next_cur.st = dspr_pkg::DSPR_H_WRITE;
                    end
                end
            end
            dspr_pkg::DSPR_H_WRITE: begin
                next_cur.req_valid = 1'b1;
                next_cur.req_write = 1'b1;
                next_cur.req_wdata = 32'h0000_0000;
                if (cur.op == dspr_pkg::DSPR_OP_RST) begin
                    next_cur.req_addr = `DSPR_OFS_RSTRR;
                    next_cur.req_wdata[`DSPR_BIT_RR] = cur.val;
                end else begin
                    // 1 starts, 0 ends or withdraws
                    next_cur.req_addr = dom_addr(`DSPR_OFS_PCR, cur.dom);
                    next_cur.req_wdata[`DSPR_BIT_PR] = cur.op == dspr_pkg::DSPR_OP_ON;
                end
                next_cur.st = dspr_pkg::DSPR_H_WR_W;
            end
            dspr_pkg::DSPR_H_WR_W: begin
                if (link.rsp_valid) begin
                    next_cur.st = dspr_pkg::DSPR_H_ACK;
                end
            end
            dspr_pkg::DSPR_H_ACK: begin
                // read the reset acknowledge
                next_cur.req_valid = 1'b1;
                next_cur.req_write = 1'b0;
                next_cur.req_addr  = `DSPR_OFS_RSTAR;
                next_cur.st        = dspr_pkg::DSPR_H_ACK_W;
            end
            dspr_pkg::DSPR_H_ACK_W: begin
                if (link.rsp_valid) begin
                    next_cur.ra = link.rsp_rdata[`DSPR_BIT_RA];
                    next_cur.st = dspr_pkg::DSPR_H_IDLE;
                end
            end
            default: begin
                next_cur.st = dspr_pkg::DSPR_H_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cur.st        <= dspr_pkg::DSPR_H_IDLE;
            cur.op        <= dspr_pkg::DSPR_OP_POLL;
            cur.dom       <= 5'h00;
            cur.val       <= 1'h0;
            cur.refused   <= 1'h0;
            cur.last_ps   <= 2'h0;
            cur.ra        <= 1'h0;
            cur.req_valid <= 1'h0;
            cur.req_write <= 1'h0;
            cur.req_addr  <= 12'h000;
            cur.req_wdata <= 32'h0000_0000;
            cur.pready    <= 1'h0;
            cur.prdata    <= 32'h0000_0000;
            cur.pslverr   <= 1'h0;
        end else begin
            cur <= next_cur;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign o_pready       = cur.pready;
    assign o_prdata       = cur.prdata;
    assign o_pslverr      = cur.pslverr;
    assign link.req_valid = cur.req_valid;
    assign link.req_write = cur.req_write;
    assign link.req_addr  = cur.req_addr;
    assign link.req_wdata = cur.req_wdata;

endmodule

`default_nettype wire

// File: tb/dspr_link_monitor.sv
// checker for the request link and the device end outputs
`timescale 1ns/1ps
`default_nettype none
`include "dspr_params.svh"
module dspr_link_monitor (
    input  wire logic        i_clk_sys,    // register clock
    input  wire logic        i_arst_n,     // reset, active low
    input  wire logic        req_valid,    // request strobe
    input  wire logic        req_write,    // request direction
    input  wire logic [11:0] req_addr,     // request address
    input  wire logic [31:0] req_wdata,    // request data
    input  wire logic        rsp_valid,    // answer strobe
    input  wire logic [31:0] rsp_rdata,    // answer data
    input  wire logic [31:0] i_pwr_ack,    // domains powered
    input  wire logic        i_rst_ignore, // resets ignored
    input  wire logic [31:0] o_pwr_req,    // power demand
    input  wire logic        o_rst_req     // reset request
);
    // ****************************************************************
    // helper decode
    // ****************************************************************
    logic [4:0]  idx;    // domain of the request
    logic        rd_psr; // status read
    logic        wr_pcr; // request write
    logic        wr_rr0; // reset request cleared
    logic [31:0] both_q; // demand and power seen last edge
    assign idx    = req_addr[6:2];
    assign rd_psr = req_valid && !req_write && (req_addr & `DSPR_BANK_MASK) == `DSPR_OFS_PSR;
    assign wr_pcr = req_valid && req_write && (req_addr & `DSPR_BANK_MASK) == `DSPR_OFS_PCR;
    assign wr_rr0 = req_valid && req_write && req_addr == `DSPR_OFS_RSTRR && !req_wdata[0];
    // remembers which domains were demanded and powered
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) both_q <= 32'h0;
        else both_q <= o_pwr_req & i_pwr_ack;
    end
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    a_rsp_next: assert property (req_valid |=> rsp_valid)
        else $error("link answer missing");
    a_rsp_cause: assert property (rsp_valid |-> $past(req_valid))
        else $error("link answer without request");
    a_pr_demand: assert property (
        wr_pcr |=> o_pwr_req[$past(idx)] == $past(req_wdata[1]))
        else $error("power demand does not follow request bit");
    a_status_clear: assert property (rd_psr && !o_pwr_req[idx] |=> rsp_rdata == 32'h0)
        else $error("status not cleared without request");
    a_status_held: assert property (
        rd_psr && o_pwr_req[idx] && both_q[idx] |=> rsp_rdata == 32'h3)
        else $error("status not held while powered");
    a_held_demand: assert property (
        rsp_valid && rsp_rdata[1:0] == 2'h3 |-> o_pwr_req[$past(idx)])
        else $error("demand dropped while held");
    a_one_encoding: assert property (
        rd_psr |=> rsp_rdata[1:0] != 2'h1 && rsp_rdata[31:2] == 30'h0)
        else $error("status shows a second powered code");
    a_rst_hold: assert property ($fell(o_rst_req) |->
        $past(wr_rr0) || $past(wr_rr0, 2) || $past(i_rst_ignore) || $past(i_rst_ignore, 2))
        else $error("reset request dropped unasked");
    a_reset_clear: assert property ($rose(i_arst_n) |-> !o_rst_req && o_pwr_req == 32'h0)
        else $error("outputs not cleared by reset");
    c_held: cover property (rsp_valid && rsp_rdata[1:0] == 2'h3);
    c_rst: cover property ($rose(o_rst_req));
    c_clear: cover property (wr_pcr && !req_wdata[1]);
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the debug power and reset request link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        i_clk_sys, i_arst_n, psel, penable, pwrite, pready, pslverr, err;
    logic        rack, ign, rst_req, m_rr, m_ra, m_ref;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, pack, pwr_req, rd, m_pr, m_held;
    logic [1:0]  m_ps;
    int          fails, check_count, d;
    dspr_link_if dspr_link_if_i ();
    dspr_ctl dspr_ctl_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .link(dspr_link_if_i));
    dspr_dev dspr_dev_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .link(dspr_link_if_i),
        .i_pwr_ack(pack), .i_rst_ack(rack), .i_rst_ignore(ign), .o_pwr_req(pwr_req),
        .o_rst_req(rst_req));
    dspr_link_monitor dspr_link_monitor_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
        .req_valid(dspr_link_if_i.req_valid), .req_write(dspr_link_if_i.req_write),
        .req_addr(dspr_link_if_i.req_addr), .req_wdata(dspr_link_if_i.req_wdata),
        .rsp_valid(dspr_link_if_i.rsp_valid), .rsp_rdata(dspr_link_if_i.rsp_rdata),
        .i_pwr_ack(pack), .i_rst_ignore(ign), .o_pwr_req(pwr_req), .o_rst_req(rst_req));
    // ****************************************************************
    // tasks
    // ****************************************************************
    // verdict and end of run
    task automatic test_done();
        if (fails == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // compare a register value
    task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // compare an output pin set
    task automatic chk_out(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer, holds the request until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        int n;
        @(posedge i_clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge i_clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 64) begin
            fails++;
            test_done();
        end
    endtask
    // issue a command, wait while busy, update model and compare
    task automatic cmd(input logic [1:0] op, input logic [4:0] dom, input logic val);
        int n;
        apb(1'b1, 8'h00, {19'h0, val, 2'h0, op, 3'h0, dom});
        n = 0;
        do begin
            apb(1'b0, 8'h04, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 64);
        if (n >= 64) begin
            fails++;
            test_done();
        end
        m_held = (m_held | (m_pr & pack)) & m_pr;
        m_ref = (op == 2'h1) & m_held[dom];
        if (op < 2'h2) m_ps = m_held[dom] ? 2'h3 : 2'h0;
        if (op == 2'h1 && !m_ref) m_pr[dom] = 1'b1;
        if (op == 2'h2) m_pr[dom] = 1'b0;
        if (op == 2'h3 && !ign) m_rr = val;
        m_held = (m_held | (m_pr & pack)) & m_pr;
        if (m_rr && !ign && rack) m_ra = 1'b1;
        else if (!m_rr && !rack) m_ra = 1'b0;
        chk_reg("status", {27'h0, m_ra, m_ps, m_ref, 1'b0}, rd);
        chk_out("pwr_req", m_pr, pwr_req);
        chk_out("rst_req", {31'h0, m_rr & ~ign}, {31'h0, rst_req});
    endtask
    // ****************************************************************
    // clock and main sequence
    // ****************************************************************
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        void'($urandom(9987));
        {psel, penable, pwrite, paddr, pwdata, pack, rack, ign} = '0;
        {m_pr, m_held, m_rr, m_ra, m_ref, m_ps} = '0;
        fails = 0;
        check_count = 0;
        i_arst_n = 1'b0;
        repeat (3) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        apb(1'b0, 8'h04, 32'h0);
        chk_reg("status", 32'h0, rd);
        apb(1'b1, 8'h08, $urandom());
        chk_reg("pslverr", 32'h1, {31'h0, err});
        // four-phase power handshake on random domains
        for (int k = 0; k < 3; k++) begin
            d = $urandom_range(31, 0);
            cmd(2'h1, d[4:0], 1'b0);
            pack[d] <= 1'b1;
            cmd(2'h0, d[4:0], 1'b0);
            pack[d] <= 1'b0;
            cmd(2'h1, d[4:0], 1'b0);
            cmd(2'h2, d[4:0], 1'b0);
            cmd(2'h0, d[4:0], 1'b0);
        end
        cmd(2'h1, d[4:0], 1'b0);
        cmd(2'h2, d[4:0], 1'b0);
        // system reset handshake, then a write while ignored
        cmd(2'h3, 5'h0, 1'b1);
        rack <= 1'b1;
        cmd(2'h0, 5'h0, 1'b0);
        cmd(2'h3, 5'h0, 1'b0);
        rack <= 1'b0;
        cmd(2'h0, 5'h0, 1'b0);
        ign <= 1'b1;
        cmd(2'h3, 5'h0, 1'b1);
        ign <= 1'b0;
        cmd(2'h0, 5'h0, 1'b0);
        // reset in mid-run with a request standing
        cmd(2'h3, 5'h0, 1'b1);
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        @(posedge i_clk_sys);
        chk_out("rst_req", 32'h0, {31'h0, rst_req});
        test_done();
    end
endmodule
`default_nettype wire
